// ---- sse_defs.vh ----
// Shared constants for the sleep and subtract execution block
`ifndef SSE_DEFS_VH
`define SSE_DEFS_VH
`define SSE_OP_SLEEP      16'h0003
`define SSE_OP_LIT_TOP    4'hB
`define SSE_OP_FSUB_TOP   7'h02
`define SSE_OP_FSUBB_TOP  7'h01
`define SSE_DEST_BIT      8
`define SSE_WDT_RESET     8'h00
`define SSE_POST_RESET    8'h00
`define SSE_ACC_RESET     8'h00
`define SSE_Q1            2'h0
`define SSE_Q2            2'h1
`define SSE_Q3            2'h2
`define SSE_Q4            2'h3
`endif

// ---- sse_sub_unit.v ----
// Eight-bit subtractor with borrow in and status outputs
`timescale 1ns/1ps
module sse_sub_unit
(
    input  wire [7:0] minuend,
    input  wire [7:0] subtrahend,
    input  wire       carryIn,
    output wire [7:0] diff,
    output wire       carryOut,
    output wire       digitCarry,
    output wire       overflow,
    output wire       zero
);
    wire [8:0] full;
    wire [4:0] low;
    // Subtract as a plus not b plus carry; carry out high means no borrow
    assign full       = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, carryIn};
    assign low        = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carryIn};
    assign diff       = full[7:0];
    assign carryOut   = full[8];
    assign digitCarry = low[4];
    assign overflow   = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ full[7]);
    assign zero       = (full[7:0] == 8'h00);
endmodule // sse_sub_unit

// ---- sse_exec.v ----
// Execution stage for power-down and the three subtract instructions
//
// Summary of operation
// - Power-down opcode halts execution and stops the oscillator at cycle end.
// - Power-down clears the power-down status bit.
// - Power-down sets the time-out status bit.
// - Power-down clears the watchdog counter and its postscaler.
// - Watchdog wake-up from power-down clears the time-out status bit.
// - Literal subtract computes literal minus accumulator into the accumulator.
// - Subtracts update overflow, carry, digit carry, zero; power-down only status bits.
// - File subtract computes file register minus accumulator, two's complement.
// - File subtract decoded by upper byte 0000 010d; low byte is address.
// - Destination bit 0 writes accumulator, 1 writes file register.
// - Borrow form subtracts accumulator and inverted carry from the file register.
`timescale 1ns/1ps
`include "sse_defs.vh"
module sse_exec
#(
    parameter WDT_WIDTH = 8
)
(
    input  wire                 mclk,
    input  wire                 rst_n,
    input  wire                 instrValid,
    input  wire [15:0]          instrWord,
    input  wire [7:0]           fileRdData,
    input  wire                 wdtWake,
    input  wire                 otherWake,
    output reg  [7:0]           fileAddr_q,
    output reg                  fileRd_q,
    output reg                  fileWr_q,
    output reg  [7:0]           fileWrData_q,
    output reg  [7:0]           workingAccumulator_q,
    output reg                  overflowFlag_q,
    output reg                  carryFlag_q,
    output reg                  digitCarryFlag_q,
    output reg                  zeroFlag_q,
    output reg                  timeoutStatusBit_q,
    output reg                  powerdownStatusBit_q,
    output reg  [WDT_WIDTH-1:0] watchdogCounter_q,
    output reg  [7:0]           wdtPostscaler_q,
    output reg                  wdtClear_q,
    output reg                  sleeping_q,
    output reg                  oscRun_q,
    output reg                  busy_q
);
    localparam OP_NONE  = 3'h0;
    localparam OP_SLEEP = 3'h1;
    localparam OP_LIT   = 3'h2;
    localparam OP_FSUB  = 3'h3;
    localparam OP_FSUBB = 3'h4;

    // Phase, latched word and operand held across one instruction
    reg  [1:0]  phase_q;
    reg  [15:0] instr_q;
    reg  [2:0]  op_q;
    reg  [7:0]  operand_q;
    reg  [2:0]  opDec;
    // Subtractor results, consumed at the Q4 edge
    wire [7:0]  diff;
    wire        cOut;
    wire        digOut;
    wire        ovfOut;
    wire        zOut;

    // True for the two forms whose operand, and destination when bit 8 is set, is a file register
    function isFileOp;
        input [2:0] op;
        begin
            isFileOp = (op == OP_FSUB) || (op == OP_FSUBB);
        end
    endfunction

    // Instruction decode from the latched word
    always @*
    begin
        if (instr_q == `SSE_OP_SLEEP)
            opDec = OP_SLEEP;
        else if (instr_q[15:12] == `SSE_OP_LIT_TOP)
            opDec = OP_LIT;
        else if (instr_q[15:9] == `SSE_OP_FSUB_TOP)
            opDec = OP_FSUB;
        else if (instr_q[15:9] == `SSE_OP_FSUBB_TOP)
            opDec = OP_FSUBB;
        else
            opDec = OP_NONE;
    end

    // Subtractor; borrow form uses carry as inverted borrow, others carry in one
    sse_sub_unit uSub
    (
        .minuend    (operand_q),
        .subtrahend (workingAccumulator_q),
        .carryIn    ((op_q == OP_FSUBB) ? carryFlag_q : 1'b1),
        .diff       (diff),
        .carryOut   (cOut),
        .digitCarry (digOut),
        .overflow   (ovfOut),
        .zero       (zOut)
    );

    // Q phase sequencer and instruction execution
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            phase_q              <= `SSE_Q1;
            instr_q              <= 16'h0000;
            op_q                 <= OP_NONE;
            operand_q            <= 8'h00;
            fileAddr_q           <= 8'h00;
            fileRd_q             <= 1'b0;
            fileWr_q             <= 1'b0;
            fileWrData_q         <= 8'h00;
            workingAccumulator_q <= `SSE_ACC_RESET;
            overflowFlag_q       <= 1'b0;
            carryFlag_q          <= 1'b0;
            digitCarryFlag_q     <= 1'b0;
            zeroFlag_q           <= 1'b0;
            timeoutStatusBit_q   <= 1'b1;
            powerdownStatusBit_q <= 1'b1;
            watchdogCounter_q    <= {WDT_WIDTH{1'b0}};
            wdtPostscaler_q      <= `SSE_POST_RESET;
            wdtClear_q           <= 1'b0;
            sleeping_q           <= 1'b0;
            oscRun_q             <= 1'b1;
            busy_q               <= 1'b0;
        end
        else if (sleeping_q)
        begin
            // Halted with oscillator off until a wake source arrives
            fileWr_q   <= 1'b0;
            wdtClear_q <= 1'b0;
            // Instruction words are ignored here; a wake restarts at Q1
            if (wdtWake || otherWake)
            begin
                sleeping_q <= 1'b0;
                oscRun_q   <= 1'b1;
                phase_q    <= `SSE_Q1;
                // Only a watchdog wake clears the time-out bit
                if (wdtWake)
                    timeoutStatusBit_q <= 1'b0;
            end
        end
        else
        begin
            fileRd_q   <= 1'b0;
            fileWr_q   <= 1'b0;
            wdtClear_q <= 1'b0;
            case (phase_q)
                `SSE_Q1:
                begin
                    // Decode: latch the word for this cycle
                    if (instrValid)
                    begin
                        instr_q <= instrWord;
                        busy_q  <= 1'b1;
                        phase_q <= `SSE_Q2;
                    end
                    else
                        busy_q <= 1'b0;
                end
                `SSE_Q2:
                begin
                    // Operand read: literal or file register
                    op_q       <= opDec;
                    fileAddr_q <= instr_q[7:0];
                    fileRd_q   <= isFileOp(opDec);
                    phase_q    <= `SSE_Q3;
                end
                `SSE_Q3:
                begin
                    // Process: capture operand from literal or file data
                    operand_q <= (op_q == OP_LIT) ? instr_q[7:0] : fileRdData;
                    phase_q   <= `SSE_Q4;
                end
                `SSE_Q4:
                begin
                    // Write result to destination or enter sleep
                    phase_q <= `SSE_Q1;
                    busy_q  <= 1'b0;
                    case (op_q)
                        OP_SLEEP:
                        begin
                            // Halt lands on the Q4 edge together with the status bits
                            powerdownStatusBit_q <= 1'b0;
                            timeoutStatusBit_q   <= 1'b1;
                            watchdogCounter_q    <= {WDT_WIDTH{1'b0}};
                            wdtPostscaler_q      <= `SSE_POST_RESET;
                            wdtClear_q           <= 1'b1;
                            sleeping_q           <= 1'b1;
                            oscRun_q             <= 1'b0;
                        end
                        OP_LIT, OP_FSUB, OP_FSUBB:
                        begin
                            // Flags from every subtract; word bit 8 picks the destination for the two file forms only
                            overflowFlag_q   <= ovfOut;
                            carryFlag_q      <= cOut;
                            digitCarryFlag_q <= digOut;
                            zeroFlag_q       <= zOut;
                            if (isFileOp(op_q) && instr_q[`SSE_DEST_BIT])
                            begin
                                fileWr_q     <= 1'b1;
                                fileWrData_q <= diff;
                            end
                            else
                                workingAccumulator_q <= diff;
                        end
                        default:
                        begin
                            // Unrecognised word: four phases with no effect
                            fileWr_q <= 1'b0;
                        end
                    endcase
                end
                default:
                    phase_q <= `SSE_Q1;
            endcase
        end
    end
endmodule // sse_exec

// ---- sse_exec_assertions.sv ----
// Port-level assertions for the execution block
`timescale 1ns/1ps
module sse_exec_chk
#(
    parameter WDT_WIDTH = 8
)
(
    input wire                 mclk,
    input wire                 rst_n,
    input wire                 instrValid,
    input wire                 wdtWake,
    input wire                 fileRd_q,
    input wire                 fileWr_q,
    input wire [7:0]           fileWrData_q,
    input wire                 zeroFlag_q,
    input wire                 timeoutStatusBit_q,
    input wire                 powerdownStatusBit_q,
    input wire [WDT_WIDTH-1:0] watchdogCounter_q,
    input wire [7:0]           wdtPostscaler_q,
    input wire                 wdtClear_q,
    input wire                 sleeping_q,
    input wire                 oscRun_q,
    input wire                 busy_q
);
    // One clock domain throughout
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // Power-down entry, status bits and watchdog clearing
    a_halt_osc: assert property (sleeping_q == !oscRun_q)
        else $error("oscillator state disagrees with halt");
    a_sleep_status: assert property ($rose(sleeping_q) |->
        !powerdownStatusBit_q && timeoutStatusBit_q) else $error("status bits wrong on sleep");
    a_sleep_dog: assert property ($rose(sleeping_q) |-> wdtClear_q &&
        watchdogCounter_q == 0 && wdtPostscaler_q == 8'h00) else $error("watchdog not cleared");
    a_dog_wake: assert property (sleeping_q && wdtWake |=> !timeoutStatusBit_q)
        else $error("watchdog wake left time-out bit set");
    // Instruction timing and file strobes
    a_take_four: assert property (!busy_q && !sleeping_q && instrValid |=>
        busy_q [*3] ##1 !busy_q) else $error("instruction not four phases");
    a_rd_strobe: assert property (fileRd_q |-> busy_q ##1 !fileRd_q)
        else $error("read strobe not a single busy cycle");
    a_wr_after_rd: assert property ($rose(fileWr_q) |-> $past(fileRd_q, 2))
        else $error("write strobe not two cycles after read");
    a_wr_zero: assert property (fileWr_q |-> zeroFlag_q == (fileWrData_q == 8'h00))
        else $error("zero flag disagrees with written result");
endmodule // sse_exec_chk

// ---- test_sse_exec.sv ----
// Self-checking bench for the execution block
`timescale 1ns/1ps
`include "sse_defs.vh"
module test_sse_exec;
    reg        mclk, rst_n, instrValid, wdtWake, otherWake;
    reg [15:0] instrWord;
    reg [7:0]  fileRdData, eAcc, eRes, k;
    reg        eC, eDig, eOvf, eZ;
    wire [7:0] fAddr, fWrData, acc, dogCnt, dogPost;
    wire       fRd, fWr, ovfF, cF, digF, zF, tmoBit, pdnBit, dogClr, sleeping, oscRun, busy;
    integer    n_mismatch, compares, cycles, i;
    sse_exec dut_u (.mclk(mclk), .rst_n(rst_n), .instrValid(instrValid), .instrWord(instrWord),
        .fileRdData(fileRdData), .wdtWake(wdtWake), .otherWake(otherWake), .fileAddr_q(fAddr),
        .fileRd_q(fRd), .fileWr_q(fWr), .fileWrData_q(fWrData), .workingAccumulator_q(acc),
        .overflowFlag_q(ovfF), .carryFlag_q(cF), .digitCarryFlag_q(digF), .zeroFlag_q(zF),
        .timeoutStatusBit_q(tmoBit), .powerdownStatusBit_q(pdnBit), .watchdogCounter_q(dogCnt),
        .wdtPostscaler_q(dogPost), .wdtClear_q(dogClr), .sleeping_q(sleeping),
        .oscRun_q(oscRun), .busy_q(busy));
    // Counts a compare and reports a mismatch
    task chk(input ok, input [8*8-1:0] msg);
    begin
        compares = compares + 1;
        if (ok !== 1'b1)
        begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR %0t: %0s", $time, msg);
        end
    end
    endtask
    // Reference subtract a - b - !cin
    task sub(input [7:0] a, input [7:0] b, input cin);
        reg [8:0] s;
        reg [4:0] h;
    begin
        s = {1'b0, a} + {1'b0, ~b} + cin;
        h = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + cin;
        eRes = s[7:0];
        eC = s[8];
        eDig = h[4];
        eZ = (eRes == 8'h00);
        eOvf = (a[7] != b[7]) && (eRes[7] != a[7]);
    end
    endtask
    // Issues one word and waits until its Q4 results land
    task run(input [15:0] w, input [7:0] fd);
    begin
        instrWord = w;
        fileRdData = fd;
        instrValid = 1'b1;
        @(posedge mclk);
        #1 instrValid = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
    end
    endtask
    task chkF;
        chk(cF === eC && zF === eZ && digF === eDig && ovfF === eOvf, "flags");
    endtask
    // Literal subtracts through zero, overflow and borrow
    task t_lit;
    begin
        for (i = 0; i < 6; i = i + 1)
        begin
            k = (i == 0) ? 8'h01 : (i == 1) ? 8'h02 : (i == 2) ? 8'h01 : (i == 3) ? 8'h03
                : (i == 4) ? 8'h80 : 8'h00;
            sub(k, eAcc, 1'b1);
            run({4'hB, 4'h0, k}, 8'h5A);
            eAcc = eRes;
            chk(acc === eAcc, "lit acc");
            chkF;
        end
        $display("t_lit done");
    end
    endtask
    // File subtract and borrow form to both destinations, end addresses
    task t_file;
    begin
        for (i = 0; i < 4; i = i + 1)
        begin
            k = (i == 0) ? 8'h85 : (i == 1) ? 8'h01 : (i == 2) ? 8'h19 : 8'h03;
            sub(k, eAcc, (i < 2) ? 1'b1 : eC);
            run({(i < 2) ? 7'h02 : 7'h01, i[0], i[1] ? 8'h00 : 8'hFF}, k);
            chk(fAddr === (i[1] ? 8'h00 : 8'hFF), "addr");
            if (!i[0])
                eAcc = eRes;
            chk(acc === eAcc && fWr === i[0], "dest");
            chk(!i[0] || fWrData === eRes, "wr data");
            chkF;
        end
        run(16'h0600, 8'h77);
        chk(acc === eAcc && fWr === 1'b0 && sleeping === 1'b0, "no op");
        chkF;
        $display("t_file done");
    end
    endtask
    // Power-down, refused word while halted, both wake sources
    task t_sleep;
    begin
        for (i = 0; i < 2; i = i + 1)
        begin
            run(`SSE_OP_SLEEP, 8'h00);
            chk(sleeping === 1'b1 && oscRun === 1'b0, "halt");
            chk(pdnBit === 1'b0 && tmoBit === 1'b1, "status");
            chk(dogCnt === 8'h00 && dogPost === 8'h00 && dogClr === 1'b1, "dog");
            chkF;
            run({4'hB, 4'h0, 8'h55}, 8'h00);
            chk(acc === eAcc && sleeping === 1'b1, "refused");
            wdtWake = !i[0];
            otherWake = i[0];
            repeat (2) @(posedge mclk);
            #1 chk(sleeping === 1'b0 && tmoBit === i[0], "wake");
            wdtWake = 1'b0;
            otherWake = 1'b0;
            @(posedge mclk);
            #1;
        end
        $display("t_sleep done");
    end
    endtask
    // Prints the counts and the verdict
    task stop_test;
    begin
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    // Clock and hang guard
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cycles = cycles + 1;
        if (cycles == 5000)
        begin
            n_mismatch = n_mismatch + 1;
            stop_test;
        end
    end
    // Main sequence
    initial
    begin
        {rst_n, instrValid, wdtWake, otherWake, instrWord, fileRdData} = 0;
        {n_mismatch, compares, cycles, eAcc} = 0;
        repeat (5) @(posedge mclk);
        #1 rst_n = 1'b1;
        chk(tmoBit === 1'b1 && pdnBit === 1'b1 && oscRun === 1'b1 && acc === 8'h00, "reset");
        t_lit;
        t_file;
        t_sleep;
        stop_test;
    end
endmodule // test_sse_exec
bind sse_exec sse_exec_chk #(.WDT_WIDTH(WDT_WIDTH)) chk_u (.mclk, .rst_n, .instrValid, .wdtWake,
    .fileRd_q, .fileWr_q, .fileWrData_q, .zeroFlag_q, .timeoutStatusBit_q, .powerdownStatusBit_q,
    .watchdogCounter_q, .wdtPostscaler_q, .wdtClear_q, .sleeping_q, .oscRun_q, .busy_q);
